// [common/fru_params.svh]
// constants for the fixed rate uart channel
// assumes mclk at 200 mhz and a sync active-high reset
`ifndef FRU_PARAMS_SVH
`define FRU_PARAMS_SVH
`define FRU_CLK_HZ 200000000
`define FRU_BAUD 9575
`define FRU_BIT_CYC (`FRU_CLK_HZ / `FRU_BAUD)
`define FRU_HALF_CYC (`FRU_CLK_HZ / (`FRU_BAUD * 2))
`define FRU_DATA_RST 8'hff
`define FRU_FIFO_DEPTH 8
`define FRU_ERR_PAR 0
`define FRU_ERR_FRM 1
`define FRU_ERR_OVR 2
`endif

// [common/fru_pkg.sv]
// types shared by the uart channel modules
// assumes fru_params.svh is on the include path
package fru_pkg;
    typedef enum logic [1:0] {
        FRU_PAR_NONE,
        FRU_PAR_ZERO,
        FRU_PAR_ODD,
        FRU_PAR_EVEN
    } fru_parity_t;
    typedef enum logic [1:0] {
        FRU_MODE_OFF,
        FRU_MODE_TX,
        FRU_MODE_RX,
        FRU_MODE_TXRX
    } fru_mode_t;
endpackage : fru_pkg

// [common/fru_stream_if.sv]
// valid/ready byte stream between the channel and its fifo
// assumes one clock for both ends
`timescale 1ns/1ps
interface fru_stream_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : fru_stream_if

// [logic/fru_fifo.sv]
// small synchronous fifo, registered read data
// assumes one clock, sync active-high reset
`timescale 1ns/1ps
module fru_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk,
    input wire logic rst,
    fru_stream_if.snk wr,
    fru_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [W-1:0] dout_r;
    logic dval_r;
    logic push;
    logic pop;
    logic empty;
    assign empty = (cnt_r == '0);
    assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
    assign push = wr.valid && wr.ready;
    // output stage refills when empty or being taken
    assign pop = !empty && (!dval_r || rd.ready);
    assign rd.valid = dval_r;
    assign rd.data = dout_r;
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_r] <= wr.data;
        end
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    // registered read side
    always_ff @(posedge mclk) begin
        if (rst) begin
            dval_r <= 1'b0;
            dout_r <= '0;
        end else if (pop) begin
            dval_r <= 1'b1;
            dout_r <= mem[rp_r];
        end else if (rd.ready) begin
            dval_r <= 1'b0;
        end
    end
endmodule : fru_fifo

// [logic/fru_uart.sv]
// fixed rate uart channel: tx shifter, rx sampler, status
// assumes rxd already synchronous to mclk; config held steady
`timescale 1ns/1ps
`include "fru_params.svh"
// Behaviour
// - receiver samples the line only while receive enable is set
// - start bit accepted only if line still low half a bit later
// - line high at check point: no reception, re-arm and keep watching
// - tx write starts frame: start, 7/8 data, parity, 1/2 stops
// - seven-bit characters drop the transmit byte's top bit
// - receiver always expects exactly one stop bit
// - receiver takes start, data, parity, one stop, then buffers
// - tx or rx completion sets the serial interrupt request flag
// - status loaded with error bits only when an error occurred
// - reading the receive buffer clears the status register
// - aborted transfer leaves tx register dirty; refill with ffh
// - setting tx enable shifts out whatever the tx register holds
// - normal transmit completion leaves tx register at ffh
// - every reset makes both buffers ffh; pin direction follows the mode, not reset
// - one flag serves both directions; two events may merge
// - fixed 9575 bps from internal clock, lsb first
// - even, odd, zero and no parity handled
// - framing error on low stop; overrun still stores data
// - error irq mask gates completion interrupt on rx error
module fru_uart
    import fru_pkg::*;
#(
    parameter int BIT_CYC = `FRU_BIT_CYC,
    parameter int HALF_CYC = `FRU_HALF_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire fru_mode_t mode,
    input wire fru_parity_t parity_sel,
    input wire logic char_len8,
    input wire logic stop_two,
    input wire logic rx_error_irq_mask_flag,
    input wire logic clocked_mode_enable_flag,
    input wire logic tx_enable_flag,
    input wire logic rx_enable_flag,
    input wire logic tx_wr,
    input wire logic [7:0] tx_wdata,
    output logic tx_busy,
    output logic [7:0] tx_shift_register,
    input wire logic rxd,
    output logic txd_o,
    output logic txd_oe,
    input wire logic rx_rd,
    output logic [7:0] rx_buffer_register,
    output logic rx_pending,
    output logic [2:0] async_status,
    input wire logic irq_clr,
    output logic serial_irq_request_flag
);
    // ********************************************************
    // timing
    // ********************************************************
    localparam int CW = $clog2(BIT_CYC + 1);

    logic uart_on;
    logic tx_mode;
    logic rx_mode;
    assign uart_on = !clocked_mode_enable_flag;
    assign tx_mode = uart_on && (mode == FRU_MODE_TX || mode == FRU_MODE_TXRX);
    assign rx_mode = uart_on && (mode == FRU_MODE_RX || mode == FRU_MODE_TXRX);

    // ********************************************************
    // transmit fifo path
    // ********************************************************
    fru_stream_if #(.W(8)) tx_in ();
    fru_stream_if #(.W(8)) tx_out ();
    assign tx_in.valid = tx_wr && tx_mode;
    assign tx_in.data = tx_wdata;

    fru_fifo #(.W(8), .DEPTH(`FRU_FIFO_DEPTH)) u_txq (
        .mclk(mclk),
        .rst(rst),
        .wr(tx_in.snk),
        .rd(tx_out.src)
    );

    typedef enum logic [2:0] {
        FRU_TX_IDLE,
        FRU_TX_START,
        FRU_TX_DATA,
        FRU_TX_PAR,
        FRU_TX_STOP
    } fru_txst_t;
    fru_txst_t tx_st_r;
    logic [CW-1:0] tx_cnt_r;
    logic [3:0] tx_bit_r;
    logic [7:0] tx_sh_r;
    logic tx_par_r;
    logic tx_line_r;
    logic tx_done;
    logic tx_tick;
    logic tx_go;
    logic txen_d_r;
    logic [3:0] nbits;
    assign nbits = char_len8 ? 4'h8 : 4'h7;
    assign tx_tick = (tx_cnt_r == CW'(BIT_CYC - 1));
    // either a fifo word or re-enable of the transmitter starts a frame
    assign tx_go = tx_mode && tx_enable_flag && tx_out.valid;
    assign tx_out.ready = (tx_st_r == FRU_TX_IDLE) && tx_mode && tx_enable_flag;
    assign tx_done = (tx_st_r == FRU_TX_STOP) && tx_tick
        && (tx_bit_r == (stop_two ? 4'h1 : 4'h0));

    always_ff @(posedge mclk) begin
        if (rst) begin
            txen_d_r <= 1'b1; // a flag held through reset is no new edge
        end else begin
            txen_d_r <= tx_enable_flag;
        end
    end

    // transmit sequencer; lsb first at the fixed rate
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_st_r <= FRU_TX_IDLE;
            tx_cnt_r <= '0;
            tx_bit_r <= '0;
            tx_sh_r <= `FRU_DATA_RST;
            tx_par_r <= 1'b0;
            tx_line_r <= 1'b1;
        end else if (!tx_enable_flag || !tx_mode) begin
            // abort leaves the shift data dirty, software refills
            tx_st_r <= FRU_TX_IDLE;
            tx_line_r <= 1'b1;
        end else begin
            tx_cnt_r <= tx_tick ? '0 : tx_cnt_r + 1'b1;
            case (tx_st_r)
                FRU_TX_IDLE: begin
                    tx_cnt_r <= '0;
                    if (tx_go) begin
                        tx_sh_r <= tx_out.data;
                        tx_st_r <= FRU_TX_START;
                        tx_line_r <= 1'b0;
                    end else if (tx_enable_flag && !txen_d_r) begin
                        // enable alone shifts out the held byte
                        tx_st_r <= FRU_TX_START;
                        tx_line_r <= 1'b0;
                    end
                end
                FRU_TX_START: begin
                    if (tx_tick) begin
                        tx_st_r <= FRU_TX_DATA;
                        tx_bit_r <= '0;
                        tx_line_r <= tx_sh_r[0];
                        // parity over the char bits only
                        tx_par_r <= char_len8 ? ^tx_sh_r : ^tx_sh_r[6:0];
                    end
                end
                FRU_TX_DATA: begin
                    if (tx_tick) begin
                        // shift in ones so a finished frame leaves ffh
                        tx_sh_r <= {1'b1, tx_sh_r[7:1]};
                        tx_bit_r <= tx_bit_r + 1'b1;
                        if (tx_bit_r == nbits - 4'h1) begin
                            tx_sh_r <= `FRU_DATA_RST;
                            tx_bit_r <= '0;
                            if (parity_sel == FRU_PAR_NONE) begin
                                tx_st_r <= FRU_TX_STOP;
                                tx_line_r <= 1'b1;
                            end else begin
                                tx_st_r <= FRU_TX_PAR;
                                case (parity_sel)
                                    FRU_PAR_EVEN: tx_line_r <= tx_par_r;
                                    FRU_PAR_ODD: tx_line_r <= !tx_par_r;
                                    default: tx_line_r <= 1'b0;
                                endcase
                            end
                        end else begin
                            tx_line_r <= tx_sh_r[1];
                        end
                    end
                end
                FRU_TX_PAR: begin
                    if (tx_tick) begin
                        tx_st_r <= FRU_TX_STOP;
                        tx_line_r <= 1'b1;
                    end
                end
                FRU_TX_STOP: begin
                    if (tx_tick) begin
                        tx_bit_r <= tx_bit_r + 1'b1;
                        if (tx_done) begin
                            tx_st_r <= FRU_TX_IDLE;
                        end
                    end
                end
                default: tx_st_r <= FRU_TX_IDLE;
            endcase
        end
    end

    assign tx_busy = (tx_st_r != FRU_TX_IDLE) || tx_out.valid;
    assign tx_shift_register = tx_sh_r;
    // pin stays a plain input until uart transmit is selected
    assign txd_o = tx_line_r;
    assign txd_oe = tx_mode;

    // ********************************************************
    // receiver
    // ********************************************************
    typedef enum logic [2:0] {
        FRU_RX_IDLE,
        FRU_RX_START,
        FRU_RX_DATA,
        FRU_RX_PAR,
        FRU_RX_STOP
    } fru_rxst_t;
    fru_rxst_t rx_st_r;
    logic [CW-1:0] rx_cnt_r;
    logic [3:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic rx_par_r;
    logic rx_done;
    logic rx_err_nxt_par;
    logic [2:0] rx_err;
    logic rx_tick;
    assign rx_tick = (rx_cnt_r == CW'(BIT_CYC - 1));

    // receive sequencer, mid-bit sampling
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_st_r <= FRU_RX_IDLE;
            rx_cnt_r <= '0;
            rx_bit_r <= '0;
            rx_sh_r <= '0;
            rx_par_r <= 1'b0;
            rx_err_nxt_par <= 1'b0;
        end else if (!rx_enable_flag || !rx_mode) begin
            rx_st_r <= FRU_RX_IDLE;
            rx_cnt_r <= '0;
        end else begin
            rx_cnt_r <= rx_tick ? '0 : rx_cnt_r + 1'b1;
            case (rx_st_r)
                FRU_RX_IDLE: begin
                    rx_cnt_r <= '0;
                    if (!rxd) begin
                        rx_st_r <= FRU_RX_START;
                    end
                end
                FRU_RX_START: begin
                    if (rx_cnt_r == CW'(HALF_CYC - 1)) begin
                        rx_cnt_r <= '0;
                        if (!rxd) begin
                            rx_st_r <= FRU_RX_DATA;
                            rx_bit_r <= '0;
                            rx_par_r <= 1'b0;
                        end else begin
                            rx_st_r <= FRU_RX_IDLE;
                        end
                    end
                end
                FRU_RX_DATA: begin
                    if (rx_tick) begin
                        rx_bit_r <= rx_bit_r + 1'b1;
                        rx_par_r <= rx_par_r ^ rxd;
                        // top bit reads zero for seven-bit chars
                        rx_sh_r <= char_len8 ? {rxd, rx_sh_r[7:1]}
                            : {1'b0, rxd, rx_sh_r[6:1]};
                        if (rx_bit_r == nbits - 4'h1) begin
                            rx_st_r <= (parity_sel == FRU_PAR_NONE)
                                ? FRU_RX_STOP : FRU_RX_PAR;
                        end
                    end
                end
                FRU_RX_PAR: begin
                    if (rx_tick) begin
                        rx_st_r <= FRU_RX_STOP;
                        case (parity_sel)
                            FRU_PAR_EVEN: rx_err_nxt_par <= rx_par_r ^ rxd;
                            FRU_PAR_ODD: rx_err_nxt_par <= !(rx_par_r ^ rxd);
                            default: rx_err_nxt_par <= 1'b0;
                        endcase
                    end
                end
                FRU_RX_STOP: begin
                    // single stop whatever the tx setting
                    if (rx_tick) begin
                        rx_st_r <= FRU_RX_IDLE;
                    end
                end
                default: rx_st_r <= FRU_RX_IDLE;
            endcase
            if (rx_st_r == FRU_RX_IDLE) begin
                rx_err_nxt_par <= 1'b0;
            end
        end
    end

    assign rx_done = rx_enable_flag && rx_mode
        && (rx_st_r == FRU_RX_STOP) && rx_tick;
    always_comb begin
        rx_err = 3'h0;
        rx_err[`FRU_ERR_PAR] = rx_err_nxt_par && (parity_sel != FRU_PAR_NONE);
        rx_err[`FRU_ERR_FRM] = !rxd;
        rx_err[`FRU_ERR_OVR] = rx_pending;
    end

    // buffer and pending flag; new data wins over a same-cycle read
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_buffer_register <= `FRU_DATA_RST;
            rx_pending <= 1'b0;
        end else if (rx_done) begin
            rx_buffer_register <= rx_sh_r;
            rx_pending <= 1'b1;
        end else if (rx_rd) begin
            rx_pending <= 1'b0;
        end
    end

    // status: loaded only on error, cleared by buffer read
    always_ff @(posedge mclk) begin
        if (rst) begin
            async_status <= 3'h0;
        end else if (rx_done && (rx_err != 3'h0)) begin
            async_status <= async_status | rx_err;
        end else if (rx_rd) begin
            async_status <= 3'h0;
        end
    end

    // ********************************************************
    // completion request flag, shared by both directions
    // ********************************************************
    logic rx_irq;
    assign rx_irq = rx_done && !((rx_err != 3'h0) && rx_error_irq_mask_flag);
    always_ff @(posedge mclk) begin
        if (rst) begin
            serial_irq_request_flag <= 1'b0;
        end else if (tx_done || rx_irq) begin
            serial_irq_request_flag <= 1'b1;
        end else if (irq_clr) begin
            serial_irq_request_flag <= 1'b0;
        end
    end
endmodule : fru_uart

// [testbench/fru_uart_properties.sv]
// port-level checks for the fixed rate uart channel
// assumes it is bound onto fru_uart; one clock, sync reset
`timescale 1ns/1ps
module fru_uart_checker
    import fru_pkg::*;
#(
    parameter int BIT_CYC = 20887
) (
    input wire logic mclk,
    input wire logic rst,
    input wire fru_mode_t mode,
    input wire logic clocked_mode_enable_flag,
    input wire logic tx_enable_flag,
    input wire logic rx_enable_flag,
    input wire logic rx_error_irq_mask_flag,
    input wire logic tx_wr,
    input wire logic rx_rd,
    input wire logic irq_clr,
    input wire logic tx_busy,
    input wire logic [7:0] tx_shift_register,
    input wire logic txd_o,
    input wire logic txd_oe,
    input wire logic [7:0] rx_buffer_register,
    input wire logic rx_pending,
    input wire logic [2:0] async_status,
    input wire logic serial_irq_request_flag
);
    logic [31:0] low_run_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ****
    // helper: length of the current low stretch on the line
    // ****
    always_ff @(posedge mclk) begin
        if (rst || txd_o) begin
            low_run_r <= 32'h0;
        end else begin
            low_run_r <= low_run_r + 32'h1;
        end
    end
    // ****
    // checks
    // ****
    chk_line_idle: assert property (!tx_busy |-> txd_o)
        else $error("line not high while transmitter idle");
    chk_wr_busy: assert property (tx_wr && txd_oe |-> ##[1:3] tx_busy)
        else $error("write did not start the transmitter");
    chk_oe_mode: assert property (txd_oe == (mode[0] && !clocked_mode_enable_flag))
        else $error("line drive does not follow the mode");
    // low stretches on the line are whole bit times
    chk_bit_time: assert property ($rose(txd_o) |-> low_run_r % BIT_CYC == 0)
        else $error("low stretch not a whole number of bits");
    chk_tx_clean: assert property ($fell(tx_busy) && tx_enable_flag |-> ##[0:1] tx_shift_register == 8'hff)
        else $error("transmit register not ff after frame");
    chk_irq_hold: assert property (serial_irq_request_flag && !irq_clr |=> serial_irq_request_flag)
        else $error("interrupt request dropped without clear");
    chk_rx_irq: assert property ($rose(rx_pending) && !rx_error_irq_mask_flag |-> ##[0:2] serial_irq_request_flag)
        else $error("reception did not raise interrupt");
    chk_rx_gate: assert property ($rose(rx_pending) |-> rx_enable_flag)
        else $error("reception completed while receiver disabled");
    chk_err_mask: assert property (rx_error_irq_mask_flag && !$past(serial_irq_request_flag) && async_status != 3'h0 && $changed(async_status) |-> !serial_irq_request_flag [*3])
        else $error("masked error raised interrupt");
    chk_rd_clear: assert property (rx_rd |=> async_status == 3'h0)
        else $error("buffer read left status set");
    chk_reset_val: assert property ($fell(rst) |-> tx_shift_register == 8'hff && rx_buffer_register == 8'hff && async_status == 3'h0 && !serial_irq_request_flag)
        else $error("wrong values after reset");
endmodule : fru_uart_checker

bind fru_uart fru_uart_checker #(.BIT_CYC(BIT_CYC)) u_chk (.mclk, .rst,
    .mode, .clocked_mode_enable_flag, .tx_enable_flag, .rx_enable_flag,
    .rx_error_irq_mask_flag, .tx_wr, .rx_rd, .irq_clr, .tx_busy,
    .tx_shift_register, .txd_o, .txd_oe, .rx_buffer_register, .rx_pending,
    .async_status, .serial_irq_request_flag);

// [testbench/fru_remote.sv]
// remote serial device: sends frames, listens to the line
// assumes mclk at 200 mhz and an idle-high line
`timescale 1ns/1ps
module fru_remote #(
    parameter int BIT_CYC = 20887 // fixed rate, lsb first
) (
    input wire logic mclk,
    input wire logic txd,
    output logic rxd
);
    initial rxd = 1'b1;
    // bits go out in order; last bit cut to tail cycles so a next
    // frame can follow tightly
    task automatic send_bits(input logic [11:0] bits, input int n,
        input int tail);
        int i;
        for (i = 0; i < n; i++) begin
            @(negedge mclk);
            rxd = bits[i];
            repeat ((i == n - 1) ? tail : BIT_CYC - 1) @(negedge mclk);
        end
        rxd = 1'b1;
    endtask : send_bits
    // find the start edge, then sample mid-bit
    task automatic recv(output logic [11:0] bits, input int n);
        int i;
        bits = 12'h0;
        for (i = 0; i < 100 && txd !== 1'b0; i++) @(posedge mclk);
        repeat (BIT_CYC / 2) @(posedge mclk);
        for (i = 0; i < n; i++) begin
            bits[i] = txd;
            repeat (BIT_CYC) @(posedge mclk);
        end
    endtask : recv
endmodule : fru_remote

// [testbench/tb_top.sv]
// self-checking bench for the fixed rate uart channel
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module tb_top
    import fru_pkg::*;
;
    fru_mode_t mode;
    fru_parity_t parity_sel;
    logic mclk, rst, char_len8, stop_two, rx_error_irq_mask_flag;
    logic clocked_mode_enable_flag, tx_enable_flag, rx_enable_flag;
    logic tx_wr, rx_rd, irq_clr, rxd, txd_o, txd_oe, tx_busy, rx_pending;
    logic serial_irq_request_flag;
    logic [7:0] tx_wdata, tx_shift_register, rx_buffer_register, d;
    logic [2:0] async_status;
    logic [11:0] got, exp;
    int fails, n_tests, seed, n, i;
    // short bit time keeps the run brief; the design default is the real rate
    localparam int BIT_CYC = 40;
    localparam int HALF_CYC = 20;
    fru_uart #(.BIT_CYC(BIT_CYC), .HALF_CYC(HALF_CYC)) u_fru_uart (
        .mclk, .rst, .mode, .parity_sel, .char_len8,
        .stop_two, .rx_error_irq_mask_flag, .clocked_mode_enable_flag,
        .tx_enable_flag, .rx_enable_flag, .tx_wr, .tx_wdata, .tx_busy,
        .tx_shift_register, .rxd, .txd_o, .txd_oe, .rx_rd,
        .rx_buffer_register, .rx_pending, .async_status, .irq_clr,
        .serial_irq_request_flag);
    fru_remote #(.BIT_CYC(BIT_CYC)) u_fru_remote (.mclk, .txd(txd_o), .rxd);
    // ****
    // helpers
    // ****
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // expected frame: start, data lsb first, parity, stops
    function automatic logic [11:0] frame(input logic [7:0] v,
        input logic c8, input fru_parity_t p, input logic s2,
        output int len);
        logic [7:0] m;
        logic [11:0] b;
        int k;
        m = c8 ? v : {1'b0, v[6:0]};
        b = {3'h0, m, 1'b0};
        k = c8 ? 9 : 8;
        if (p != FRU_PAR_NONE) begin
            b[k] = (p == FRU_PAR_EVEN) ? ^m : (p == FRU_PAR_ODD) ? ~^m : 1'b0;
            k++;
        end
        b[k] = 1'b1;
        k++;
        if (s2) begin
            b[k] = 1'b1;
            k++;
        end
        len = k;
        return b;
    endfunction : frame
    task automatic check(input logic [11:0] g, input logic [11:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : check
    task automatic clr_irq();
        @(negedge mclk);
        irq_clr = 1'b1;
        @(negedge mclk);
        irq_clr = 1'b0;
    endtask : clr_irq
    // bounded wait, a frame is at most 12 bit times
    task automatic wait_idle();
        int k;
        for (k = 0; k < 20 * BIT_CYC && tx_busy !== 1'b0; k++) begin
            @(negedge mclk);
        end
        if (tx_busy !== 1'b0) begin
            fails++;
            $display("ERROR %0t transmitter stuck", $time);
        end
    endtask : wait_idle
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (300 * BIT_CYC) @(posedge mclk);
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test();
    end
    // ****
    // main sequence
    // ****
    initial begin
        seed = 32'h9d8be0ca;
        fails = 0;
        n_tests = 0;
        rst = 1'b1;
        mode = FRU_MODE_TXRX;
        parity_sel = FRU_PAR_ODD;
        char_len8 = 1'b1;
        stop_two = 1'b1;
        rx_error_irq_mask_flag = 1'b0;
        clocked_mode_enable_flag = 1'b0;
        tx_enable_flag = 1'b1;
        rx_enable_flag = 1'b0;
        tx_wr = 1'b0;
        tx_wdata = 8'h00;
        rx_rd = 1'b0;
        irq_clr = 1'b0;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
        check({4'h0, tx_shift_register}, 12'h0ff);
        check({4'h0, rx_buffer_register}, 12'h0ff);
        // one frame per parity type; bit 7 set on a 7-bit one
        // each frame sets its own parity, length and stop count, then writes data
        for (i = 0; i < 4; i++) begin
            wait_idle();
            clr_irq();
            parity_sel = fru_parity_t'(i[1:0]);
            char_len8 = ~i[0];
            stop_two = i[1] ~^ i[0];
            d = 8'($random(seed));
            if (i == 1) d[7] = 1'b1;
            exp = frame(d, char_len8, parity_sel, stop_two, n);
            fork
                u_fru_remote.recv(got, n);
                begin
                    tx_wdata = d;
                    tx_wr = 1'b1;
                    @(negedge mclk);
                    tx_wr = 1'b0;
                end
            join
            check(got, exp);
            wait_idle();
            repeat (2) @(negedge mclk);
            check({11'h0, serial_irq_request_flag}, 12'h001);
            check({4'h0, tx_shift_register}, 12'h0ff);
        end
        // enable edge alone sends the held byte, ffh after a clean frame
        tx_enable_flag = 1'b0;
        clr_irq();
        exp = frame(8'hff, char_len8, parity_sel, stop_two, n);
        fork
            u_fru_remote.recv(got, n);
            begin
                @(negedge mclk);
                tx_enable_flag = 1'b1;
            end
        join
        check(got, exp);
        // receiver off: a whole frame leaves no trace
        parity_sel = FRU_PAR_ODD;
        char_len8 = 1'b1;
        stop_two = 1'b1;
        clr_irq();
        d = 8'($random(seed));
        exp = frame(d, 1'b1, FRU_PAR_ODD, 1'b0, n);
        u_fru_remote.send_bits(exp, n, BIT_CYC * 3 / 4);
        check({10'h0, rx_pending, serial_irq_request_flag}, 12'h0);
        // short dip under half a bit, then a good frame
        rx_enable_flag = 1'b1;
        u_fru_remote.send_bits(12'h0, 1, BIT_CYC / 4);
        repeat (BIT_CYC) @(negedge mclk);
        check({10'h0, rx_pending, serial_irq_request_flag}, 12'h0);
        u_fru_remote.send_bits(exp, n, BIT_CYC * 3 / 4);
        check({4'h0, rx_buffer_register}, {4'h0, d});
        check({7'h0, rx_pending, serial_irq_request_flag, async_status}, 12'h018);
        // unread, masked, bad parity, two stops set but one sent
        clr_irq();
        rx_error_irq_mask_flag = 1'b1;
        d = 8'($random(seed));
        exp = frame(d, 1'b1, FRU_PAR_ODD, 1'b0, n);
        exp[9] = ~exp[9];
        u_fru_remote.send_bits(exp, n, BIT_CYC * 3 / 4);
        check({4'h0, rx_buffer_register}, {4'h0, d});
        check({7'h0, rx_pending, serial_irq_request_flag, async_status}, 12'h015);
        @(negedge mclk);
        rx_rd = 1'b1; // status was looked at first
        @(negedge mclk);
        rx_rd = 1'b0;
        @(negedge mclk);
        check({9'h0, async_status}, 12'h0);
        // 7-bit frame with a low stop bit, error irq allowed
        rx_error_irq_mask_flag = 1'b0;
        char_len8 = 1'b0;
        parity_sel = FRU_PAR_EVEN;
        d = 8'($random(seed));
        d[7] = 1'b1;
        exp = frame(d, 1'b0, FRU_PAR_EVEN, 1'b0, n);
        exp[n - 1] = 1'b0;
        u_fru_remote.send_bits(exp, n, BIT_CYC * 3 / 4);
        check({4'h0, rx_buffer_register}, {5'h0, d[6:0]});
        check({7'h0, rx_pending, serial_irq_request_flag, async_status}, 12'h01a);
        end_of_test();
    end
endmodule : tb_top
